//--- logic/equalizer_control_registers.sv
// Behaviour
// - bit 7 reads carrier detect, ignores writes
// - mute and bypass bits; mute beats bypass
// - sleep field: on, auto, forced, reserved
// - sleep overrides mute and bypass
// - driver select picks driver register copy
// - master reset restores defaults, self-clears
// - acquisition reset restarts adaptation only
// - swing field bits 7:6, reset 10
// - common-mode offset bits 5:4, reset 10
// - de-emphasis enable bit 3, reset 0
// - de-emphasis level bits 2:1, reset 01
// - all fields reached over the serial port
// - 16-bit frame: command, address, data
// - writes land when slave select rises
`timescale 1ns/100ps
`include "eq_ctrl_params.svh"
module equalizer_control_registers
   import eq_ctrl_pkg::*;
#(
   parameter int NUM_DRIVERS = 2
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic sck_in,
   input wire logic ss_n_in,
   input wire logic mosi_in,
   input wire logic carrier_in,
   output logic miso_out,
   output logic mute_out,
   output logic bypass_out,
   output logic powerdown_out,
   output logic sm_reset_out,
   output logic carrier_out,
   output logic [NUM_DRIVERS-1:0][1:0] swing_out,
   output logic [NUM_DRIVERS-1:0][1:0] offset_out,
   output logic [NUM_DRIVERS-1:0] deemph_en_out,
   output logic [NUM_DRIVERS-1:0][1:0] deemph_lvl_out
);

   generate
      if (NUM_DRIVERS != 2) begin : g_bad_drivers
         $error("driver select is one bit: exactly two drivers");
      end
      // the frame and field layout must match the decode below
      if (`FRAME_BITS != 16) begin : g_bad_frame
         $error("a frame is sixteen bits");
      end
      if (`FRAME_CMD_BIT != `FRAME_BITS - 1) begin : g_bad_cmd
         $error("the command bit leads the frame");
      end
      if (`FRAME_ADDR_HI - `FRAME_ADDR_LO != 6) begin : g_bad_addr
         $error("the address field is seven bits");
      end
      if (`FRAME_ADDR_LO != `FRAME_DATA_HI + 1) begin : g_bad_gap
         $error("the address sits right above the data");
      end
      if (`FRAME_DATA_HI - `FRAME_DATA_LO != 7) begin : g_bad_data
         $error("the data field is eight bits");
      end
      if (`GEN_CTRL_ADDR == `DRV_CFG_ADDR) begin : g_bad_map
         $error("the two registers need distinct addresses");
      end
      if (`GC_SLEEP_HI - `GC_SLEEP_LO != 1) begin : g_bad_sleep
         $error("the sleep field is two bits");
      end
      if (`GC_MRST_BIT == `GC_ARST_BIT) begin : g_bad_resets
         $error("the two reset fields need distinct bits");
      end
      if (`SLEEP_RESET == 2'h3) begin : g_bad_sleep_rst
         $error("the sleep reset code must not be the reserved one");
      end
      if (`DC_CFG_HI - `DC_CFG_LO + 1 != $bits(drv_cfg_s)) begin : g_bad_cfg
         $error("the driver field span must match the driver record");
      end
      if (`DC_RSVD_BIT != `DC_CFG_LO - 1) begin : g_bad_rsvd
         $error("the reserved bit sits below the driver fields");
      end
      if (`DC_SWING_LO != `DC_OFFSET_HI + 1) begin : g_bad_swing
         $error("swing and offset fields must be adjacent");
      end
      if (`DC_OFFSET_LO != `DC_DEEMPH_BIT + 1) begin : g_bad_offset
         $error("offset and enable fields must be adjacent");
      end
      if (`DC_DEEMPH_BIT != `DC_LEVEL_HI + 1) begin : g_bad_level
         $error("enable and level fields must be adjacent");
      end
      if (`DC_LEVEL_LO != `DC_CFG_LO) begin : g_bad_span
         $error("the level field ends the driver fields");
      end
   endgenerate

   localparam int PIN_SCK = 0;
   localparam int PIN_SS = 1;
   localparam int PIN_MOSI = 2;
   localparam int PIN_CARRIER = 3;
   localparam logic [4:0] FRAME_COUNT = 5'(`FRAME_BITS);
   // slave select idles high; the other pins reset low
   localparam logic [3:0] PIN_IDLE = 4'(1 << PIN_SS);

   typedef struct packed {
      logic [`FRAME_BITS-1:0] shift;
      logic [4:0] bits;
      logic mute;
      logic bypass;
      sleep_mode_e sleep;
      logic drv_sel;
      drv_cfg_s [1:0] drv;
      logic miso;
      logic mute_o;
      logic bypass_o;
      logic powerdown_o;
      logic sm_reset;
      logic carrier_o;
   } ctrl_state_s;

   localparam drv_cfg_s DRV_RST = '{
      swing: `SWING_RESET,
      offset: `OFFSET_RESET,
      deemph_en: `DEEMPH_EN_RESET,
      deemph_lvl: `DEEMPH_LVL_RESET};

   localparam ctrl_state_s STATE_RST = '{
      shift: '0,
      bits: '0,
      mute: `MUTE_RESET,
      bypass: `BYPASS_RESET,
      sleep: sleep_mode_e'(`SLEEP_RESET),
      drv_sel: `DRVSEL_RESET,
      drv: {DRV_RST, DRV_RST},
      miso: 1'h0,
      mute_o: 1'h0,
      bypass_o: 1'h0,
      powerdown_o: 1'h0,
      sm_reset: 1'h0,
      carrier_o: 1'h0};

   wire [3:0] pin_vec;

   assign pin_vec[PIN_SCK] = sck_in;
   assign pin_vec[PIN_SS] = ss_n_in;
   assign pin_vec[PIN_MOSI] = mosi_in;
   assign pin_vec[PIN_CARRIER] = carrier_in;

   pin_sync_if #(.W(4)) pins_if ();

   pin_sync #(
      .W(4),
      .RST_VAL(PIN_IDLE)
   ) u_pin_sync (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .pins_in(pin_vec),
      .sync_if(pins_if)
   );

   ctrl_state_s state_ff;
   ctrl_state_s nxt_state;
   logic sel_now;
   logic carrier;
   logic sck_rise;
   logic ss_low;
   logic ss_rise;
   logic ss_fall;
   logic frame_done;
   logic is_write;
   logic [6:0] frame_addr;
   logic [7:0] frame_data;
   logic [7:0] read_data;
   logic sleeping;
   logic addr_gen;
   logic addr_drv;
   logic master_req;
   logic acq_req;

   assign carrier = pins_if.level[PIN_CARRIER];
   assign sck_rise = pins_if.rise[PIN_SCK];
   assign ss_low = ~pins_if.level[PIN_SS];
   assign ss_rise = pins_if.rise[PIN_SS];
   assign ss_fall = pins_if.fall[PIN_SS];

   always_comb begin
      nxt_state = state_ff;
      nxt_state.sm_reset = 1'h0;
      sel_now = state_ff.drv_sel;
      frame_done = ss_rise && (state_ff.bits == FRAME_COUNT);
      is_write = (state_ff.shift[`FRAME_CMD_BIT] == `CMD_WRITE);
      frame_addr = state_ff.shift[`FRAME_ADDR_HI:`FRAME_ADDR_LO];
      frame_data = state_ff.shift[`FRAME_DATA_HI:`FRAME_DATA_LO];
      addr_gen = (frame_addr == `GEN_CTRL_ADDR);
      addr_drv = (frame_addr == `DRV_CFG_ADDR);
      master_req = frame_data[`GC_MRST_BIT];
      acq_req = frame_data[`GC_ARST_BIT];
      read_data = `UNMAPPED_READ;
      if (addr_gen) begin
         read_data[`GC_CARRIER_BIT] = carrier;
         read_data[`GC_MUTE_BIT] = state_ff.mute;
         read_data[`GC_BYPASS_BIT] = state_ff.bypass;
         read_data[`GC_SLEEP_HI:`GC_SLEEP_LO] = state_ff.sleep;
         read_data[`GC_DRVSEL_BIT] = state_ff.drv_sel;
         // self-clearing reset bits always read back as zero
         read_data[`GC_MRST_BIT] = 1'h0;
         read_data[`GC_ARST_BIT] = 1'h0;
      end else if (addr_drv) begin
         read_data[`DC_SWING_HI:`DC_SWING_LO] =
            state_ff.drv[sel_now].swing;
         read_data[`DC_OFFSET_HI:`DC_OFFSET_LO] =
            state_ff.drv[sel_now].offset;
         read_data[`DC_DEEMPH_BIT] =
            state_ff.drv[sel_now].deemph_en;
         read_data[`DC_LEVEL_HI:`DC_LEVEL_LO] =
            state_ff.drv[sel_now].deemph_lvl;
         read_data[`DC_RSVD_BIT] = 1'h0;
      end

      if (ss_fall) begin
         nxt_state.bits = '0;
      end
      if (sck_rise && ss_low) begin
         nxt_state.shift = {state_ff.shift[`FRAME_BITS-2:0],
            pins_if.level[PIN_MOSI]};
         if (state_ff.bits != FRAME_COUNT) begin
            nxt_state.bits = state_ff.bits + 5'h1;
         end
      end

      // frames act only when slave select returns high
      if (frame_done) begin
         if (!is_write) begin
            // reply waits in the low byte for the next transaction
            nxt_state.shift[`FRAME_DATA_HI:`FRAME_DATA_LO] = read_data;
         end else if (addr_gen) begin
            if (master_req) begin
               nxt_state.mute = STATE_RST.mute;
               nxt_state.bypass = STATE_RST.bypass;
               nxt_state.sleep = STATE_RST.sleep;
               nxt_state.drv_sel = STATE_RST.drv_sel;
               nxt_state.drv = STATE_RST.drv;
               nxt_state.sm_reset = 1'h1;
            end else begin
               nxt_state.mute = frame_data[`GC_MUTE_BIT];
               nxt_state.bypass = frame_data[`GC_BYPASS_BIT];
               nxt_state.sleep = sleep_mode_e'(
                  frame_data[`GC_SLEEP_HI:`GC_SLEEP_LO]);
               nxt_state.drv_sel = frame_data[`GC_DRVSEL_BIT];
               nxt_state.sm_reset = acq_req;
            end
         end else if (addr_drv) begin
            // bit 0 is dropped: the reserved bit holds no state
            nxt_state.drv[sel_now].swing =
               frame_data[`DC_SWING_HI:`DC_SWING_LO];
            nxt_state.drv[sel_now].offset =
               frame_data[`DC_OFFSET_HI:`DC_OFFSET_LO];
            nxt_state.drv[sel_now].deemph_en =
               frame_data[`DC_DEEMPH_BIT];
            nxt_state.drv[sel_now].deemph_lvl =
               frame_data[`DC_LEVEL_HI:`DC_LEVEL_LO];
         end
      end

      nxt_state.miso = state_ff.shift[`FRAME_BITS-1];
      nxt_state.carrier_o = carrier;

      unique case (nxt_state.sleep)
         SLEEP_NEVER: sleeping = 1'h0;
         SLEEP_AUTO: sleeping = ~carrier;
         SLEEP_FORCE: sleeping = 1'h1;
         // reserved code is treated as never sleep
         SLEEP_RSVD: sleeping = 1'h0;
      endcase
      nxt_state.powerdown_o = sleeping;
      nxt_state.mute_o = nxt_state.mute & ~sleeping;
      nxt_state.bypass_o = nxt_state.bypass & ~nxt_state.mute
         & ~sleeping;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_ff <= STATE_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign miso_out = state_ff.miso;
   assign mute_out = state_ff.mute_o;
   assign bypass_out = state_ff.bypass_o;
   assign powerdown_out = state_ff.powerdown_o;
   assign sm_reset_out = state_ff.sm_reset;
   assign carrier_out = state_ff.carrier_o;

   genvar d;
   generate
      for (d = 0; d < NUM_DRIVERS; d++) begin : g_drv
         assign swing_out[d] = state_ff.drv[d].swing;
         assign offset_out[d] = state_ff.drv[d].offset;
         assign deemph_en_out[d] = state_ff.drv[d].deemph_en;
         assign deemph_lvl_out[d] = state_ff.drv[d].deemph_lvl;
      end
   endgenerate

endmodule : equalizer_control_registers

//--- logic/eq_ctrl_params.svh
`ifndef EQ_CTRL_PARAMS_SVH
`define EQ_CTRL_PARAMS_SVH

// register addresses inside the 7-bit address field
`define GEN_CTRL_ADDR 7'h00
`define DRV_CFG_ADDR 7'h01

// general_control field positions
`define GC_CARRIER_BIT 7
`define GC_MUTE_BIT 6
`define GC_BYPASS_BIT 5
`define GC_SLEEP_HI 4
`define GC_SLEEP_LO 3
`define GC_DRVSEL_BIT 2
`define GC_MRST_BIT 1
`define GC_ARST_BIT 0

// output_driver_config field positions
`define DC_CFG_HI 7
`define DC_CFG_LO 1
`define DC_RSVD_BIT 0
`define DC_SWING_HI 7
`define DC_SWING_LO 6
`define DC_OFFSET_HI 5
`define DC_OFFSET_LO 4
`define DC_DEEMPH_BIT 3
`define DC_LEVEL_HI 2
`define DC_LEVEL_LO 1

// reset values
`define MUTE_RESET 1'h0
`define BYPASS_RESET 1'h0
`define SLEEP_RESET 2'h1
`define DRVSEL_RESET 1'h0
`define SWING_RESET 2'h2
`define OFFSET_RESET 2'h2
`define DEEMPH_EN_RESET 1'h0
`define DEEMPH_LVL_RESET 2'h1

// frame layout
`define FRAME_BITS 16
`define FRAME_CMD_BIT 15
`define FRAME_ADDR_HI 14
`define FRAME_ADDR_LO 8
`define FRAME_DATA_HI 7
`define FRAME_DATA_LO 0
`define CMD_WRITE 1'h0
`define UNMAPPED_READ 8'h00

`endif

//--- logic/eq_ctrl_pkg.sv
package eq_ctrl_pkg;

   typedef enum logic [1:0] {
      SLEEP_NEVER = 2'b00,
      SLEEP_AUTO = 2'b01,
      SLEEP_FORCE = 2'b10,
      SLEEP_RSVD = 2'b11
   } sleep_mode_e;

   // matches bits [7:1] of output_driver_config
   typedef struct packed {
      logic [1:0] swing;
      logic [1:0] offset;
      logic deemph_en;
      logic [1:0] deemph_lvl;
   } drv_cfg_s;

endpackage : eq_ctrl_pkg

//--- logic/pin_sync_if.sv
`timescale 1ns/100ps
interface pin_sync_if #(parameter int W = 4);
   logic [W-1:0] level;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface : pin_sync_if

//--- logic/pin_sync.sv
`timescale 1ns/100ps
module pin_sync
   import eq_ctrl_pkg::*;
#(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [W-1:0] pins_in,
   pin_sync_if.src sync_if
);

   generate
      if (W < 1) begin : g_bad_width
         $error("pin_sync needs at least one bit");
      end
   endgenerate

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
      logic [W-1:0] rise;
      logic [W-1:0] fall;
   } sync_state_s;

   localparam sync_state_s STATE_RST = '{
      s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, level: RST_VAL,
      rise: '0, fall: '0};

   sync_state_s state_ff;
   sync_state_s nxt_state;
   logic [W-1:0] agree;

   always_comb begin
      nxt_state = state_ff;
      agree = ~(state_ff.s2 ^ state_ff.s3);
      nxt_state.s1 = pins_in;
      nxt_state.s2 = state_ff.s1;
      nxt_state.s3 = state_ff.s2;
      // a change counts once the second and third stage agree
      nxt_state.level = (state_ff.s2 & agree) | (state_ff.level & ~agree);
      nxt_state.rise = nxt_state.level & ~state_ff.level;
      nxt_state.fall = ~nxt_state.level & state_ff.level;
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_ff <= STATE_RST;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign sync_if.level = state_ff.level;
   assign sync_if.rise = state_ff.rise;
   assign sync_if.fall = state_ff.fall;

endmodule : pin_sync

//--- testbench/eq_ctrl_checker.sv
`timescale 1ns/100ps
module eq_ctrl_checker
   import eq_ctrl_pkg::*;
#(
   parameter int NUM_DRIVERS = 2
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic ss_n_in,
   input wire logic carrier_in,
   input wire logic miso_out,
   input wire logic mute_out,
   input wire logic bypass_out,
   input wire logic powerdown_out,
   input wire logic sm_reset_out,
   input wire logic carrier_out,
   input wire logic [NUM_DRIVERS-1:0][1:0] swing_out,
   input wire logic [NUM_DRIVERS-1:0][1:0] offset_out,
   input wire logic [NUM_DRIVERS-1:0] deemph_en_out,
   input wire logic [NUM_DRIVERS-1:0][1:0] deemph_lvl_out
);
   wire [7*NUM_DRIVERS-1:0] cfg_w = {swing_out, offset_out, deemph_en_out,
      deemph_lvl_out};

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   mute_wins_a: assert property (mute_out |-> !bypass_out)
      else $error("bypass active while muted");
   sleep_wins_a: assert property (
      powerdown_out |-> !mute_out && !bypass_out)
      else $error("mute or bypass active while asleep");
   sm_pulse_a: assert property (sm_reset_out |=> !sm_reset_out)
      else $error("state machine reset longer than one cycle");
   sm_after_ss_a: assert property (
      sm_reset_out |-> ss_n_in && $past(ss_n_in, 3))
      else $error("state machine reset outside frame end");
   cfg_after_ss_a: assert property (
      !$stable(cfg_w) |-> ss_n_in && $past(ss_n_in, 3))
      else $error("driver setting changed inside frame");
   frame_hold_a: assert property ((!ss_n_in) [*8] |-> $stable(cfg_w))
      else $error("driver setting changed while selected");
   miso_idle_a: assert property (ss_n_in [*8] |-> $stable(miso_out))
      else $error("serial out moved between frames");
   carrier_track_a: assert property (
      $rose(carrier_in) |-> ##[1:8] carrier_out)
      else $error("carrier status not followed");

   cover property (sm_reset_out);
   cover property ($rose(powerdown_out));
   cover property (!$stable(cfg_w));
endmodule : eq_ctrl_checker

bind equalizer_control_registers eq_ctrl_checker #(
   .NUM_DRIVERS(NUM_DRIVERS)
) i_eq_ctrl_checker (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .ss_n_in(ss_n_in),
   .carrier_in(carrier_in), .miso_out(miso_out), .mute_out(mute_out),
   .bypass_out(bypass_out), .powerdown_out(powerdown_out),
   .sm_reset_out(sm_reset_out), .carrier_out(carrier_out),
   .swing_out(swing_out), .offset_out(offset_out),
   .deemph_en_out(deemph_en_out), .deemph_lvl_out(deemph_lvl_out)
);

//--- testbench/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
   input wire logic clk_in,
   input wire logic miso_in,
   output logic sck_out,
   output logic ss_n_out,
   output logic mosi_out
);
   initial begin
      sck_out = 1'b0;
      ss_n_out = 1'b1;
      mosi_out = 1'b1;
   end

   // mode 0, msb first; serial clock idles low outside frames
   task automatic xfer(input int n, input logic [15:0] tx,
      output logic [15:0] rx);
      rx = '0;
      @(negedge clk_in);
      ss_n_out = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         mosi_out = tx[i];
         repeat (8) @(negedge clk_in);
         rx[i] = miso_in;
         sck_out = 1'b1;
         repeat (8) @(negedge clk_in);
         sck_out = 1'b0;
      end
      repeat (8) @(negedge clk_in);
      ss_n_out = 1'b1;
      mosi_out = ~mosi_out;
      repeat (12) @(negedge clk_in);
   endtask : xfer
endmodule : spi_host_model

//--- testbench/equalizer_control_registers_tb.sv
`timescale 1ns/100ps
module equalizer_control_registers_tb
   import eq_ctrl_pkg::*;
;
   logic clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic carrier_in = 1'b1;
   logic sck, ss_n, mosi, miso, mute, bypass, pdown, smr, carr;
   logic sm_seen = 1'b0;
   logic [1:0][1:0] swing, offset, lvl;
   logic [1:0] den;
   logic [15:0] rx;
   int fail_count = 0;
   int n_compared = 0;
   int cycles = 0;

   equalizer_control_registers #(.NUM_DRIVERS(2))
   i_equalizer_control_registers (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sck_in(sck),
      .ss_n_in(ss_n), .mosi_in(mosi), .carrier_in(carrier_in),
      .miso_out(miso), .mute_out(mute), .bypass_out(bypass),
      .powerdown_out(pdown), .sm_reset_out(smr), .carrier_out(carr),
      .swing_out(swing), .offset_out(offset), .deemph_en_out(den),
      .deemph_lvl_out(lvl)
   );

   spi_host_model i_spi_host_model (.clk_in(clk_in), .miso_in(miso),
      .sck_out(sck), .ss_n_out(ss_n), .mosi_out(mosi));

   initial forever #5 clk_in = ~clk_in;

   always @(posedge clk_in) begin
      if (smr) sm_seen <= 1'b1;
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         close_out();
      end
   end

   task automatic close_out();
      if (fail_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_spi_host_model.xfer(16, {1'b0, a, d}, rx);
   endtask : wr

   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      i_spi_host_model.xfer(16, {1'b1, a, 8'hff}, rx);
      i_spi_host_model.xfer(16, 16'hffff, rx);
      check(rx, {1'b1, a, exp});
   endtask : rd

   function automatic logic [15:0] drv(input int d);
      return {9'h0, swing[d], offset[d], den[d], lvl[d]};
   endfunction : drv

   function automatic logic [15:0] mbp();
      return 16'({mute, bypass, pdown});
   endfunction : mbp

   initial begin
      repeat (16) @(negedge clk_in);
      sys_rst_in = 1'b0;
      repeat (8) @(negedge clk_in);
      check(drv(0), 16'h51);
      check(drv(1), 16'h51);
      rd(7'h00, 8'h88);
      wr(7'h00, 8'h68);
      check(mbp(), 16'h4);
      wr(7'h00, 8'h28);
      check(mbp(), 16'h2);
      wr(7'h00, 8'h30);
      check(mbp(), 16'h1);
      wr(7'h00, 8'h48);
      check(mbp(), 16'h4);
      carrier_in = 1'b0;
      repeat (10) @(negedge clk_in);
      check(mbp(), 16'h1);
      check(16'(carr), 16'h0);
      wr(7'h00, 8'h40);
      check(mbp(), 16'h4);
      wr(7'h00, 8'hd8);
      check(mbp(), 16'h4);
      rd(7'h00, 8'h58);
      carrier_in = 1'b1;
      wr(7'h00, 8'h0c);
      check(16'(carr), 16'h1);
      wr(7'h01, 8'h23);
      check(drv(1), 16'h11);
      check(drv(0), 16'h51);
      rd(7'h01, 8'h22);
      rd(7'h00, 8'h8c);
      wr(7'h00, 8'h0c);
      i_spi_host_model.xfer(15, 16'h03fc, rx);
      check(drv(1), 16'h11);
      rd(7'h05, 8'h00);
      sm_seen = 1'b0;
      wr(7'h00, 8'h0d);
      check(16'(sm_seen), 16'h1);
      check(drv(1), 16'h11);
      rd(7'h00, 8'h8c);
      sm_seen = 1'b0;
      wr(7'h00, 8'h42);
      check(16'(sm_seen), 16'h1);
      check(drv(1), 16'h51);
      rd(7'h00, 8'h88);
      close_out();
   end
endmodule : equalizer_control_registers_tb
